// file: fps_pkg.sv
// constants for the flash program/erase host sequencer
package fps_pkg;
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned NS_PER_CLK = 50;
   // durations as printed
   localparam int unsigned PROGRAM_VERIFY_BYTE_US = 210;
   localparam int unsigned PROGRAM_VERIFY_WORD_US = 360;
   localparam int unsigned SINGLE_SECTOR_ERASE_S = 8;
   localparam int unsigned WHOLE_ARRAY_ERASE_S = 24;
   localparam int unsigned SECTOR_LOAD_WINDOW_US = 100;
   localparam int unsigned PROTECT_PULSE_WIDTH_US = 10;
   localparam int unsigned UNPROTECT_PULSE_WIDTH_MS = 12;
   localparam int unsigned OUTPUT_ENABLE_LEAD_TIME_US = 4;
   // cycle counts: each us or ms duration times the whole cycles per microsecond (truncated), the erase seconds times CLK_HZ, so no time is rounded up
   localparam longint unsigned CYC_PER_US = CLK_HZ / 1000000;
   localparam longint unsigned PROG_BYTE_CYC = PROGRAM_VERIFY_BYTE_US * CYC_PER_US;
   localparam longint unsigned PROG_WORD_CYC = PROGRAM_VERIFY_WORD_US * CYC_PER_US;
   localparam longint unsigned SECT_ERASE_CYC = longint'(SINGLE_SECTOR_ERASE_S) * CLK_HZ;
   localparam longint unsigned CHIP_ERASE_CYC = longint'(WHOLE_ARRAY_ERASE_S) * CLK_HZ;
   localparam longint unsigned LOAD_WIN_CYC = SECTOR_LOAD_WINDOW_US * CYC_PER_US;
   localparam longint unsigned PROT_PULSE_CYC = PROTECT_PULSE_WIDTH_US * CYC_PER_US;
   localparam longint unsigned UNPROT_PULSE_CYC = longint'(UNPROTECT_PULSE_WIDTH_MS) * 1000 * CYC_PER_US;
   localparam longint unsigned OE_LEAD_CYC = OUTPUT_ENABLE_LEAD_TIME_US * CYC_PER_US;
   // status bit positions on the data bus, sector address field and timer width
   localparam int unsigned POLARITY_BIT = 7;
   localparam int unsigned TOGGLE_BIT = 6;
   localparam int unsigned SECTOR_LSB = 12;
   localparam int unsigned SECTOR_MSB = 15;
   localparam int unsigned TW = 32;
   // operation codes
   localparam logic [2:0] OP_PROG_BYTE = 3'h0;
   localparam logic [2:0] OP_PROG_WORD = 3'h1;
   localparam logic [2:0] OP_SECT_ERASE = 3'h2;
   localparam logic [2:0] OP_CHIP_ERASE = 3'h3;
   localparam logic [2:0] OP_PROTECT = 3'h4;
   localparam logic [2:0] OP_UNPROTECT = 3'h5;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WRITE = 3'b001,
      ST_GAP = 3'b010,
      ST_READ = 3'b011,
      ST_LEAD = 3'b100,
      ST_PULSE = 3'b101,
      ST_DONE = 3'b110
   } fps_state_e;
endpackage

// file: fps_timer.sv
// down counter that times one interval and pulses when it runs out
module fps_timer (
   // clock and reset
   input wire logic CLK,
   input wire logic rst,
   // control
   input wire logic load,
   input wire logic [fps_pkg::TW-1:0] count,
   // state
   output logic busy,
   output logic expired
);
   logic [fps_pkg::TW-1:0] cnt_reg;
   always_ff @(posedge CLK)
   begin
      if (rst || load)
      begin
         cnt_reg <= rst ? '0 : count;
         busy <= !rst;
         expired <= 1'b0;
      end
      else
      begin
         expired <= busy && (cnt_reg == 1);
         if (busy)
         begin
            cnt_reg <= cnt_reg - 1'b1;
            busy <= (cnt_reg != 1);
         end
      end
   end
endmodule

// file: fps_host.sv
// host sequencer: issues one write, then polls the status lines or times a protect pulse
// Summary of operation
// - host starts polling once the internal verify has begun
// - extra sectors load inside the 100 us window before erase starts (host writes one sector only; the window only extends its timeout)
// - protect write strobe held at least 10 us
// - unprotect write strobe held at least 12 ms
// - output enable set at least 4 us before write strobe
module fps_host #(
   parameter longint unsigned SECT_ERASE_CYC = fps_pkg::SECT_ERASE_CYC,
   parameter longint unsigned CHIP_ERASE_CYC = fps_pkg::CHIP_ERASE_CYC,
   parameter longint unsigned UNPROT_PULSE_CYC = fps_pkg::UNPROT_PULSE_CYC
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // user request
   input wire logic START,
   input wire logic [2:0] OP,
   input wire logic [16:0] ADDR,
   input wire logic [15:0] DATA,
   output logic BUSY,
   output logic DONE,
   output logic TIMEOUT,
   output logic [15:0] RESULT,
   // flash pins
   output logic [16:0] FL_A,
   output logic FL_CE_N,
   output logic FL_OE_N,
   output logic FL_WE_N,
   output logic [15:0] FL_DQ_O,
   output logic FL_DQ_OE,
   input wire logic [15:0] FL_DQ_I
);
   fps_pkg::fps_state_e state_reg, state_next;
   logic [2:0] op_reg;
   logic [15:0] data_reg, last_reg;
   logic first_reg;
   logic t_load, t_busy, t_exp;
   logic [fps_pkg::TW-1:0] t_count;

   wire is_erase = (op_reg == fps_pkg::OP_SECT_ERASE) || (op_reg == fps_pkg::OP_CHIP_ERASE);
   wire is_prot = (op_reg == fps_pkg::OP_PROTECT) || (op_reg == fps_pkg::OP_UNPROTECT);
   // erase ends when the polarity line reads one, program when it matches the written bit
   wire pol_ok = is_erase ? FL_DQ_I[fps_pkg::POLARITY_BIT]
      : (FL_DQ_I[fps_pkg::POLARITY_BIT] == data_reg[fps_pkg::POLARITY_BIT]);
   // the operation has ended only when the toggle line is also stable between two reads
   wire tog_still = !first_reg &&
      (FL_DQ_I[fps_pkg::TOGGLE_BIT] == last_reg[fps_pkg::TOGGLE_BIT]);
   wire finished = pol_ok && tog_still;

   function automatic logic [fps_pkg::TW-1:0] op_timeout(input logic [2:0] op);
      unique case (op)
         fps_pkg::OP_PROG_BYTE: op_timeout = fps_pkg::TW'(fps_pkg::PROG_BYTE_CYC);
         fps_pkg::OP_PROG_WORD: op_timeout = fps_pkg::TW'(fps_pkg::PROG_WORD_CYC);
         fps_pkg::OP_SECT_ERASE: op_timeout = fps_pkg::TW'(SECT_ERASE_CYC + fps_pkg::LOAD_WIN_CYC);
         fps_pkg::OP_CHIP_ERASE: op_timeout = fps_pkg::TW'(CHIP_ERASE_CYC);
         fps_pkg::OP_PROTECT: op_timeout = fps_pkg::TW'(fps_pkg::PROT_PULSE_CYC);
         default: op_timeout = fps_pkg::TW'(UNPROT_PULSE_CYC);
      endcase
   endfunction

   always_comb
   begin
      state_next = state_reg;
      t_load = 1'b0;
      t_count = op_timeout(op_reg);
      unique case (state_reg)
         fps_pkg::ST_IDLE:
            if (START)
               state_next = (OP == fps_pkg::OP_PROTECT || OP == fps_pkg::OP_UNPROTECT)
                  ? fps_pkg::ST_LEAD : fps_pkg::ST_WRITE;
         fps_pkg::ST_WRITE:
         begin
            // one strobe only; the device runs program/verify itself
            state_next = fps_pkg::ST_GAP;
            t_load = 1'b1;
         end
         fps_pkg::ST_GAP:
            state_next = fps_pkg::ST_READ;
         fps_pkg::ST_READ:
            if (finished || t_exp)
               state_next = fps_pkg::ST_DONE;
         fps_pkg::ST_LEAD:
            if (t_exp)
            begin
               state_next = fps_pkg::ST_PULSE;
               t_load = 1'b1;
            end
         fps_pkg::ST_PULSE:
            if (t_exp)
               state_next = fps_pkg::ST_DONE;
         fps_pkg::ST_DONE:
            state_next = fps_pkg::ST_IDLE;
         default:
            state_next = fps_pkg::ST_IDLE;
      endcase
      if (state_reg == fps_pkg::ST_IDLE && state_next == fps_pkg::ST_LEAD)
      begin
         t_load = 1'b1;
         t_count = fps_pkg::TW'(fps_pkg::OE_LEAD_CYC);
      end
   end

   fps_timer u_timer (
      .CLK(CLK),
      .rst(RST),
      .load(t_load),
      .count(t_count),
      .busy(t_busy),
      .expired(t_exp)
   );

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         state_reg <= fps_pkg::ST_IDLE;
         op_reg <= fps_pkg::OP_PROG_BYTE;
         data_reg <= 16'h0000;
         last_reg <= 16'h0000;
         first_reg <= 1'b1;
         BUSY <= 1'b0;
         DONE <= 1'b0;
         TIMEOUT <= 1'b0;
         RESULT <= 16'h0000;
         FL_A <= 17'h0_0000;
         FL_CE_N <= 1'b1;
         FL_OE_N <= 1'b1;
         FL_WE_N <= 1'b1;
         FL_DQ_O <= 16'h0000;
         FL_DQ_OE <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         DONE <= 1'b0;
         if (state_reg == fps_pkg::ST_IDLE && START)
         begin
            op_reg <= OP;
            data_reg <= DATA;
            FL_A <= ADDR;
            FL_DQ_O <= DATA;
            BUSY <= 1'b1;
            TIMEOUT <= 1'b0;
            first_reg <= 1'b1;
         end
         FL_CE_N <= !(state_next != fps_pkg::ST_IDLE && state_next != fps_pkg::ST_DONE);
         FL_WE_N <= !(state_next == fps_pkg::ST_WRITE || state_next == fps_pkg::ST_PULSE);
         FL_DQ_OE <= (state_next == fps_pkg::ST_WRITE);
         // output enable stays low through the lead and pulse of a protect sequence
         FL_OE_N <= !(state_next == fps_pkg::ST_READ || state_next == fps_pkg::ST_LEAD
            || state_next == fps_pkg::ST_PULSE);
         if (state_reg == fps_pkg::ST_READ)
         begin
            last_reg <= FL_DQ_I;
            first_reg <= 1'b0;
            if (state_next == fps_pkg::ST_DONE)
            begin
               RESULT <= FL_DQ_I;
               TIMEOUT <= !finished;
            end
         end
         if (state_reg == fps_pkg::ST_DONE)
         begin
            BUSY <= 1'b0;
            DONE <= 1'b1;
         end
      end
   end

   logic [fps_pkg::TW-1:0] pulse_len;
   always_ff @(posedge CLK)
   begin
      if (RST || state_reg != fps_pkg::ST_PULSE)
         pulse_len <= '0;
      else
         pulse_len <= pulse_len + 1'b1;
   end

   a_pulse_width: assert property (@(posedge CLK) disable iff (RST)
      (state_reg == fps_pkg::ST_PULSE && state_next == fps_pkg::ST_DONE && !is_erase
         && op_reg == fps_pkg::OP_PROTECT) |-> pulse_len + 1 >= fps_pkg::PROT_PULSE_CYC)
      else $error("protect pulse too short");
   a_unprot_width: assert property (@(posedge CLK) disable iff (RST)
      (state_reg == fps_pkg::ST_PULSE && state_next == fps_pkg::ST_DONE
         && op_reg == fps_pkg::OP_UNPROTECT) |-> pulse_len + 1 >= UNPROT_PULSE_CYC)
      else $error("unprotect pulse too short");
   a_lead_we: assert property (@(posedge CLK) disable iff (RST)
      (state_reg == fps_pkg::ST_IDLE && state_next == fps_pkg::ST_LEAD) |=> FL_WE_N [*8])
      else $error("write strobe before lead time");
   a_single_write: assert property (@(posedge CLK) disable iff (RST)
      (state_reg == fps_pkg::ST_READ) |-> FL_WE_N && !FL_DQ_OE)
      else $error("extra write during polling");
   a_poll_oe: assert property (@(posedge CLK) disable iff (RST)
      (state_reg == fps_pkg::ST_WRITE) |=> ##1 !FL_OE_N && !FL_DQ_OE)
      else $error("polling did not begin after the write");
   a_erase_done: assert property (@(posedge CLK) disable iff (RST)
      (state_reg == fps_pkg::ST_READ && is_erase && !FL_DQ_I[fps_pkg::POLARITY_BIT] && !t_exp)
      |=> state_reg == fps_pkg::ST_READ)
      else $error("erase ended while polarity line low");
   a_prog_done: assert property (@(posedge CLK) disable iff (RST)
      (state_reg == fps_pkg::ST_READ && !is_erase && !is_prot && !t_exp
         && FL_DQ_I[fps_pkg::POLARITY_BIT] != data_reg[fps_pkg::POLARITY_BIT])
      |=> state_reg == fps_pkg::ST_READ)
      else $error("program ended on inverted bit");
   a_toggle_done: assert property (@(posedge CLK) disable iff (RST)
      (state_reg == fps_pkg::ST_READ && first_reg && !t_exp) |=> state_reg == fps_pkg::ST_READ)
      else $error("ended on first status read");
   // a new start may be taken while done is high, so busy is only checked in that cycle
   a_done_pulse: assert property (@(posedge CLK) disable iff (RST)
      DONE |-> !BUSY ##1 !DONE)
      else $error("done not a single pulse");
   a_timer_arm: assert property (@(posedge CLK) disable iff (RST)
      (state_reg == fps_pkg::ST_WRITE) |=> ##1 t_busy)
      else $error("timeout not armed");
endmodule

// file: fps_flash_model.sv
// behavioural flash device answering the host sequencer's pins
module fps_flash_model (
   // clock
   input wire logic CLK,
   // behaviour chosen by the bench
   input wire logic erase_mode,
   input wire logic [15:0] busy_cyc,
   // flash pins
   input wire logic [16:0] FL_A,
   input wire logic FL_CE_N,
   input wire logic FL_OE_N,
   input wire logic FL_WE_N,
   input wire logic [15:0] FL_DQ_O,
   output logic [15:0] FL_DQ_I,
   output logic [3:0] sector
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem = 16'h0000;
   logic [15:0] left = 16'h0000;
   logic [15:0] noise = 16'h0000;
   logic tog = 1'b0;
   logic [15:0] stat;
   always @(posedge CLK)
   begin
      noise <= noise + 16'h1357;
      if (!FL_CE_N && !FL_WE_N)
      begin
         mem <= erase_mode ? 16'hffff : FL_DQ_O;
         sector <= FL_A[15:12];
         left <= busy_cyc;
      end
      else if (left != 16'h0000)
         left <= left - 16'h0001;
      if (!FL_CE_N && !FL_OE_N && left != 16'h0000)
         tog <= ~tog;
   end
   always_comb
   begin
      stat = mem;
      stat[7] = erase_mode ? 1'b0 : ~mem[7];
      stat[6] = tog;
      // a released bus must never look like the last value
      if (FL_CE_N || FL_OE_N)
         FL_DQ_I = noise;
      else
         FL_DQ_I = (left != 16'h0000) ? stat : mem;
   end
endmodule

// file: tb_fps_host.sv
// self-checking bench for the flash program/erase host sequencer
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
   $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module tb_fps_host;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic START = 1'b0;
   logic [2:0] OP = 3'h0;
   logic [16:0] ADDR = 17'h0_0000;
   logic [15:0] DATA = 16'h0000;
   logic erase_mode = 1'b0;
   logic [15:0] busy_cyc = 16'h0000;
   logic BUSY, DONE, TIMEOUT, FL_CE_N, FL_OE_N, FL_WE_N, FL_DQ_OE;
   logic [15:0] RESULT, FL_DQ_O, FL_DQ_I;
   logic [16:0] FL_A;
   logic [3:0] sector;
   int err_total = 0;
   int check_count = 0;
   int seed = 27557;
   int oe_cnt, we_cnt, lead, dq_cnt;
   always #25 CLK = ~CLK;
   fps_host #(.SECT_ERASE_CYC(500), .CHIP_ERASE_CYC(500), .UNPROT_PULSE_CYC(500)) u_dut (
      .CLK(CLK), .RST(RST), .START(START), .OP(OP), .ADDR(ADDR), .DATA(DATA),
      .BUSY(BUSY), .DONE(DONE), .TIMEOUT(TIMEOUT), .RESULT(RESULT), .FL_A(FL_A),
      .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N), .FL_DQ_O(FL_DQ_O),
      .FL_DQ_OE(FL_DQ_OE), .FL_DQ_I(FL_DQ_I));
   fps_flash_model u_flash (
      .CLK(CLK), .erase_mode(erase_mode), .busy_cyc(busy_cyc), .FL_A(FL_A),
      .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N), .FL_DQ_O(FL_DQ_O),
      .FL_DQ_I(FL_DQ_I), .sector(sector));
   // strobe timing seen at the pins, measured per operation
   always @(posedge CLK)
   begin
      if (!FL_WE_N && we_cnt == 0)
         lead = oe_cnt;
      if (!FL_WE_N)
         we_cnt++;
      if (!FL_OE_N && FL_WE_N)
         oe_cnt++;
      if (FL_DQ_OE)
         dq_cnt++;
   end
   function automatic logic exp_q7(input logic [2:0] op, input logic [15:0] d);
      exp_q7 = (op == fps_pkg::OP_SECT_ERASE || op == fps_pkg::OP_CHIP_ERASE) ? 1'b1 : d[7];
   endfunction
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic run_op(input logic [2:0] op, input logic [16:0] a, input logic [15:0] d,
                         input logic [15:0] bc, input logic exp_to);
      int i;
      erase_mode = (op == fps_pkg::OP_SECT_ERASE || op == fps_pkg::OP_CHIP_ERASE);
      busy_cyc = bc;
      OP = op;
      ADDR = a;
      DATA = d;
      oe_cnt = 0;
      we_cnt = 0;
      dq_cnt = 0;
      lead = 0;
      START = 1'b1;
      @(posedge CLK);
      #5;
      START = 1'b0;
      for (i = 0; i < 5000 && DONE !== 1'b1; i++)
      begin
         @(posedge CLK);
         #5;
      end
      if (i == 5000)
      begin
         err_total++;
         $display("ERROR done wait expected 1 seen 0");
         conclude();
      end
      else
      begin
         `CHK("timeout", exp_to, TIMEOUT)
         `CHK("busy", 1'b0, BUSY)
         // a give-up must not come before the erase maximum plus the sector load window
         if (exp_to)
            `CHK("timeout span", 1'b1, i >= 500 + fps_pkg::LOAD_WIN_CYC)
         if (op <= fps_pkg::OP_CHIP_ERASE && !exp_to)
            `CHK("status7", exp_q7(op, d), RESULT[7])
         if (op <= fps_pkg::OP_CHIP_ERASE && !exp_to)
            `CHK("result", erase_mode ? 16'hffff : d, RESULT)
         if (op <= fps_pkg::OP_CHIP_ERASE)
            `CHK("write count", 1, we_cnt)
         `CHK("drive count", (op <= fps_pkg::OP_CHIP_ERASE) ? 1 : 0, dq_cnt)
         if (op == fps_pkg::OP_SECT_ERASE)
            `CHK("sector", a[15:12], sector)
         if (op == fps_pkg::OP_PROTECT)
            `CHK("prot width", 1'b1, we_cnt >= fps_pkg::PROT_PULSE_CYC)
         if (op == fps_pkg::OP_UNPROTECT)
            `CHK("unprot width", 1'b1, we_cnt >= 500)
         if (op >= fps_pkg::OP_PROTECT)
            `CHK("oe lead", 1'b1, lead >= fps_pkg::OE_LEAD_CYC)
         $display("test op %0d addr %0h done", op, a);
         @(posedge CLK);
         #5;
      end
   endtask
   initial
   begin
      repeat (12) @(posedge CLK);
      #5;
      RST = 1'b0;
      // corners: immediate completion, then a bit seven of both values
      run_op(fps_pkg::OP_PROG_BYTE, 17'h0_0001, 16'h0080, 16'h0000, 1'b0);
      run_op(fps_pkg::OP_PROG_WORD, 17'h1_ffff, 16'h7f7f, 16'h0040, 1'b0);
      for (int k = 0; k < 12; k++)
         run_op(3'($unsigned($random(seed)) % 4), 17'($random(seed)), 16'($random(seed)),
                16'($unsigned($random(seed)) % 60), 1'b0);
      // device stays busy past the timeout: host must give up, not hang
      run_op(fps_pkg::OP_SECT_ERASE, 17'h0_f000, 16'h0030, 16'hffff, 1'b1);
      run_op(fps_pkg::OP_CHIP_ERASE, 17'h0_0000, 16'h0010, 16'h0003, 1'b0);
      run_op(fps_pkg::OP_PROTECT, 17'h0_a000, 16'h0000, 16'h0000, 1'b0);
      run_op(fps_pkg::OP_UNPROTECT, 17'h0_0000, 16'h0000, 16'h0000, 1'b0);
      conclude();
   end
endmodule
